//--- bench/flyback_ctrl_tb.sv
// Self-checking bench for the flyback control core and its plant model.
// Assumes a shortened reset timeout of 300 cycles in the core.
`timescale 1ns/1ps
module flyback_ctrl_tb;
  logic                clk;
  logic                resetn;
  flyback_pkg::comp_t  comp_raw;
  flyback_pkg::fb_t    fb_code;
  flyback_pkg::drive_t drive;
  logic                enable;
  logic                startup_device_ctrl;
  flyback_pkg::fb_t    feedback_level;
  logic                load_heavy;
  logic                variable_freq;
  flyback_pkg::fault_t faults;
  logic                start_ok;
  logic                lock_ok;
  logic [15:0]         peak_cyc;
  logic [2:0]          inj;
  flyback_pkg::fb_t    fb_val;
  int                  error_cnt;
  int                  samples_checked;
  int                  w1;

  flyback_ctrl #(.RESET_MAX_CYC(300)) uut (
    .clk(clk), .resetn(resetn), .comp_raw(comp_raw), .fb_code(fb_code),
    .drive(drive), .enable(enable),
    .startup_device_ctrl(startup_device_ctrl),
    .feedback_level(feedback_level), .load_heavy(load_heavy),
    .variable_freq(variable_freq), .faults(faults));

  flyback_plant plant (
    .clk(clk), .resetn(resetn), .drive(drive), .comp_raw(comp_raw),
    .fb_code(fb_code), .start_ok(start_ok), .lock_ok(lock_ok),
    .peak_cyc(peak_cyc), .inj(inj), .fb_val(fb_val));

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic hang(input string msg);
    error_cnt++;
    $display("BAD %0t timeout %s", $time, msg);
    print_verdict();
  endtask

  // Width of the next drive pulse in cycles
  task automatic pulse(output int w);
    int i;
    w = 0;
    for (i = 0; i < 3000 && drive.on !== 1'b1; i++) @(negedge clk);
    if (i == 3000) hang("no pulse");
    while (drive.on === 1'b1 && w < 3000) begin
      @(negedge clk);
      w++;
    end
    if (w == 3000) hang("pulse stuck");
  endtask

  // Five cycles cover the synchroniser and register lag
  task automatic power(input logic up);
    start_ok = up;
    lock_ok = up;
    repeat (5) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_start();
    int i;
    int w2;
    start_ok = 1'b1;
    lock_ok = 1'b1;
    for (i = 0; i < 8 && enable !== 1'b1; i++) begin
      chk(startup_device_ctrl, 1, "startup before enable");
      @(negedge clk);
    end
    chk(enable, 1, "enable after start");
    chk(startup_device_ctrl, 0, "startup with enable");
    pulse(w1);
    pulse(w2);
    chk(w2 - w1, 16'h0010, "soft-start step");
    chk(feedback_level, fb_val, "aux sample");
    chk(variable_freq, 0, "fixed frequency");
    chk(load_heavy, 0, "no class in soft-start");
  endtask

  task automatic t_peak();
    int w;
    peak_cyc = 16'h001E;
    pulse(w);
    chk(w >= 30 && w <= 36, 1, "peak stop");
    peak_cyc = 16'hFFFF;
  endtask

  task automatic t_lockout();
    int w;
    power(1'b0);
    chk(enable, 0, "enable after lockout");
    chk(startup_device_ctrl, 1, "startup released");
    chk(drive.on, 0, "drive in lockout");
    chk(faults, 0, "faults in lockout");
    power(1'b1);
    pulse(w);
    pulse(w);
    chk(w, w1 + 16, "fresh soft-start");
  endtask

  task automatic t_fault(input logic [2:0] code, input int b, input int lim);
    int i;
    int n;
    inj = code;
    // Overcurrent only trips once the current ramp reaches its limit
    peak_cyc = (code == 3'h4) ? 16'h001E : 16'hFFFF;
    for (i = 0; i < lim && faults[b] !== 1'b1; i++) @(negedge clk);
    if (i == lim) hang("fault wait");
    chk(faults, 16'h0001 << b, "fault bits");
    chk(enable, 1, "biased after fault");
    chk(startup_device_ctrl, 0, "startup held low");
    inj = 3'h0;
    peak_cyc = 16'hFFFF;
    n = 0;
    for (i = 0; i < 1500; i++) begin
      @(negedge clk);
      n += (drive.on !== 1'b0);
    end
    chk(n, 0, "switching after fault");
    power(1'b0);
    chk(faults, 0, "faults after lockout");
    power(1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    start_ok = 1'b0;
    lock_ok = 1'b0;
    peak_cyc = 16'hFFFF;
    inj = 3'h0;
    fb_val = 8'h9A;
    error_cnt = 0;
    samples_checked = 0;
    w1 = 0;
    repeat (3) @(negedge clk);
    chk(drive.on, 0, "drive in reset");
    chk(enable, 0, "enable in reset");
    chk(startup_device_ctrl, 1, "startup in reset");
    resetn = 1'b1;
    @(negedge clk);
    t_start();
    t_peak();
    t_lockout();
    t_fault(3'h1, 0, 3000);
    t_fault(3'h2, 1, 3000);
    t_fault(3'h3, 6, 3000);
    t_fault(3'h4, 4, 8000);
    t_fault(3'h5, 3, 3000);
    print_verdict();
  end
endmodule // flyback_ctrl_tb

//--- bench/flyback_plant.sv
// Behavioural power switch and transformer, seen from the control core.
// Assumes the bench sets supply levels, fault injection and feedback.
`timescale 1ns/1ps
module flyback_plant (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Control side
  input  wire flyback_pkg::drive_t drive,
  output flyback_pkg::comp_t       comp_raw,
  output flyback_pkg::fb_t         fb_code,
  // Bench knobs
  input  wire logic                start_ok,
  input  wire logic                lock_ok,
  input  wire logic [15:0]         peak_cyc,
  input  wire logic [2:0]          inj,
  input  wire flyback_pkg::fb_t    fb_val
);
  logic [15:0] on_cnt;
  logic [7:0]  demag;
  logic        hit;

  ////////////////////////////////////////////////////////////////////////
  // Demagnetising lasts a fixed 40 cycles, so the aux fall comes unless code 1 or 2 is injected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      on_cnt <= 16'h0000;
      demag  <= 8'h00;
    end else begin
      on_cnt <= drive.on ? on_cnt + 16'h0001 : 16'h0000;
      if (drive.on)
        demag <= 8'h28;
      else if (demag != 8'h00)
        demag <= demag - 8'h01;
    end
  end

  assign hit = drive.on && on_cnt >= peak_cyc;

  ////////////////////////////////////////////////////////////////////////
  // Codes: 1 dead aux, 2 stuck aux, 3 overvoltage, 4 overcurrent, 5 current sense stuck tripped
  always_comb begin
    comp_raw.start_ok = start_ok;
    comp_raw.lock_ok  = lock_ok;
    comp_raw.ipeak    = hit || inj == 3'h5;
    comp_raw.overcurrent_protect      = hit && inj == 3'h4;
    comp_raw.vsense   = inj == 3'h2 ||
                        (inj != 3'h1 && demag != 8'h00 && !drive.on);
    comp_raw.overvoltage_protect      = inj == 3'h3;
  end

  assign fb_code = fb_val;
endmodule // flyback_plant

//--- rtl/cycle_timer.sv
// Saturating cycle counter, cleared to zero by a one-cycle request.
// Assumes the owner clears it on each phase or cycle boundary.
`timescale 1ns/1ps
module cycle_timer #(
  parameter int unsigned W = 14
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Control
  input  wire logic         clear,
  output logic      [W-1:0] count
);

  logic [W-1:0] count_d;

  always_comb begin
    if (clear) begin
      count_d = '0;
    end else if (&count) begin
      count_d = count;
    end else begin
      count_d = count + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else begin
      count <= count_d;
    end
  end

endmodule // cycle_timer

//--- rtl/flyback_ctrl.sv
// Flyback primary-side control core: start-up, soft-start, switching
// cycle, constant-voltage loop and protections.
// Assumes comparator outputs arrive asynchronously; feedback code is a
// clock-synchronous converter word.
`timescale 1ns/1ps
module flyback_ctrl #(
  parameter int unsigned RESET_MAX_CYC = flyback_pkg::RESET_MAX_CYC_DEF
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // Analog front end
  input  wire flyback_pkg::comp_t comp_raw,
  input  wire flyback_pkg::fb_t   fb_code,
  // Switch drive
  output flyback_pkg::drive_t     drive,
  // Start-up
  output logic                    enable,
  output logic                    startup_device_ctrl,
  // Status
  output flyback_pkg::fb_t        feedback_level,
  output logic                    load_heavy,
  output logic                    variable_freq,
  output flyback_pkg::fault_t     faults
);

  localparam flyback_pkg::cnt_t RESET_LIM =
    flyback_pkg::cnt_t'(RESET_MAX_CYC);

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers and timers

  flyback_pkg::comp_t comp_s;
  flyback_pkg::cnt_t  phase_cnt;
  flyback_pkg::cnt_t  cycle_cnt;
  flyback_pkg::phase_t ph_q, ph_d;
  flyback_pkg::mode_t  mode_q, mode_d;

  sync2 #(.W($bits(flyback_pkg::comp_t))) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .din    (comp_raw),
    .dout   (comp_s)
  );

  cycle_timer #(.W(flyback_pkg::CNT_W)) u_phase_tmr (
    .clk    (clk),
    .resetn (resetn),
    .clear  (ph_d != ph_q),
    .count  (phase_cnt)
  );

  cycle_timer #(.W(flyback_pkg::CNT_W)) u_cycle_tmr (
    .clk    (clk),
    .resetn (resetn),
    .clear  ((ph_d == flyback_pkg::PH_ON) && (ph_q != flyback_pkg::PH_ON)),
    .count  (cycle_cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  // State

  flyback_pkg::cnt_t   ss_q, ss_d;
  flyback_pkg::cnt_t   ton_q, ton_d;
  flyback_pkg::cnt_t   toff_q, toff_d;
  logic [2:0]          ocp_cnt_q, ocp_cnt_d;
  logic                seen_q, seen_d;
  logic                vs_prev_q;
  flyback_pkg::fb_t    fbl_q, fbl_d;
  flyback_pkg::fb_t    fb_hist_q [flyback_pkg::SAMPLE_LAG];
  flyback_pkg::fault_t faults_q, faults_d, flt_new;
  flyback_pkg::drive_t drive_q, drive_d;
  logic                enable_q, startup_q;
  logic                heavy_q, varfreq_q;

  logic                active;
  logic                vs_fall;
  logic                on_done;
  logic                period_done;
  logic                ss_done;
  flyback_pkg::cnt_t   ton_lim;
  flyback_pkg::fb_t    fb_sample;
  flyback_pkg::fb_t    err;
  flyback_pkg::cnt_t   ton_step;
  flyback_pkg::cnt_t   toff_step;

  assign active  = (mode_q == flyback_pkg::ST_SOFTSTART) ||
                   (mode_q == flyback_pkg::ST_REGULATE);
  assign vs_fall = vs_prev_q && !comp_s.vsense;
  // Soft-start ceiling only narrows the pulse, never widens it
  assign ton_lim = ((mode_q == flyback_pkg::ST_SOFTSTART) && (ss_q < ton_q))
                   ? ss_q : ton_q;
  assign on_done = (flyback_pkg::cnt_t'(phase_cnt + 14'h0001) >= ton_lim);
  // Off-time extension beyond the fixed period lowers the frequency
  assign period_done = (flyback_pkg::cnt_t'(cycle_cnt + 14'h0001) >=
                        flyback_pkg::cnt_t'(flyback_pkg::PERIOD_CYC +
                                            toff_q));
  // Oldest history word: taken just before the knee, where the
  // secondary current is small and repeatable
  assign fb_sample = fb_hist_q[flyback_pkg::SAMPLE_LAG-1];
  // Error amplifier: integral action, step scales with the error
  assign err = (fb_sample > flyback_pkg::FB_REF)
               ? flyback_pkg::fb_t'(fb_sample - flyback_pkg::FB_REF)
               : flyback_pkg::fb_t'(flyback_pkg::FB_REF - fb_sample);
  assign ton_step  = flyback_pkg::cnt_t'(err);
  assign toff_step = flyback_pkg::cnt_t'({err, 2'b00});

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    mode_d    = mode_q;
    ph_d      = ph_q;
    ss_d      = ss_q;
    ton_d     = ton_q;
    toff_d    = toff_q;
    ocp_cnt_d = ocp_cnt_q;
    seen_d    = seen_q;
    fbl_d     = fbl_q;
    flt_new   = '0;
    ss_done   = 1'b0;

    case (ph_q)
      flyback_pkg::PH_IDLE: begin
        if (active) begin
          ph_d = flyback_pkg::PH_ON;
        end
      end
      flyback_pkg::PH_ON: begin
        // Current already tripped at turn-on: sense path is broken
        if ((phase_cnt == '0) && comp_s.ipeak) begin
          flt_new.isense = 1'b1;
        end
        if (comp_s.ipeak || comp_s.overcurrent_protect || on_done) begin
          ph_d   = flyback_pkg::PH_RESET;
          seen_d = 1'b0;
          if (comp_s.overcurrent_protect) begin
            if (ocp_cnt_q == (flyback_pkg::OCP_LIMIT - 3'h1)) begin
              flt_new.overcurrent_protect = 1'b1;
            end
            ocp_cnt_d = ocp_cnt_q + 3'h1;
          end else begin
            ocp_cnt_d = 3'h0;
          end
          if (!comp_s.ipeak && !comp_s.overcurrent_protect &&
              (ton_lim == flyback_pkg::TON_MAX_CYC)) begin
            flt_new.max_on = 1'b1;
          end
        end
      end
      flyback_pkg::PH_RESET: begin
        if (comp_s.vsense) begin
          seen_d = 1'b1;
        end
        if (vs_fall) begin
          ph_d  = flyback_pkg::PH_WAIT;
          fbl_d = fb_sample;
          if (comp_s.overvoltage_protect) begin
            flt_new.overvoltage_protect = 1'b1;
          end
          if (mode_q == flyback_pkg::ST_SOFTSTART) begin
            if ((flyback_pkg::TON_MAX_CYC - ss_q) > flyback_pkg::SS_STEP) begin
              ss_d = ss_q + flyback_pkg::SS_STEP;
            end else begin
              ss_d    = flyback_pkg::TON_MAX_CYC;
              ss_done = 1'b1;
            end
          end else if (mode_q == flyback_pkg::ST_REGULATE) begin
            if (fb_sample < flyback_pkg::FB_SCP) begin
              flt_new.short_circuit_protect = 1'b1;
            end
            // Heavy load trims on-time; light load stretches off-time
            if (fb_sample > flyback_pkg::FB_REF) begin
              if ((toff_q == '0) && (ton_q > flyback_pkg::TON_LIGHT)) begin
                if ((ton_q - flyback_pkg::TON_LIGHT) > ton_step) begin
                  ton_d = ton_q - ton_step;
                end else begin
                  ton_d = flyback_pkg::TON_LIGHT;
                end
              end else if ((flyback_pkg::TOFF_MAX - toff_q) > toff_step) begin
                toff_d = toff_q + toff_step;
              end else begin
                toff_d = flyback_pkg::TOFF_MAX;
              end
            end else if (fb_sample < flyback_pkg::FB_REF) begin
              if (toff_q != '0) begin
                if (toff_q > toff_step) begin
                  toff_d = toff_q - toff_step;
                end else begin
                  toff_d = '0;
                end
              end else if ((flyback_pkg::TON_MAX_CYC - ton_q) > ton_step) begin
                ton_d = ton_q + ton_step;
              end else begin
                ton_d = flyback_pkg::TON_MAX_CYC;
              end
            end
          end
        end else if (!seen_q && (phase_cnt >= flyback_pkg::VS_WAIT_CYC)) begin
          flt_new.no_sense = 1'b1;
        end else if (flyback_pkg::cnt_t'(phase_cnt + 14'h0001) >= RESET_LIM) begin
          flt_new.reset_to = 1'b1;
        end
      end
      flyback_pkg::PH_WAIT: begin
        if (period_done) begin
          ph_d = flyback_pkg::PH_ON;
        end
      end
      default: begin
        ph_d = flyback_pkg::PH_IDLE;
      end
    endcase

    case (mode_q)
      flyback_pkg::ST_LOCKOUT: begin
        if (comp_s.start_ok) begin
          mode_d = flyback_pkg::ST_SOFTSTART;
        end
      end
      flyback_pkg::ST_SOFTSTART, flyback_pkg::ST_REGULATE: begin
        if (ss_done) begin
          mode_d = flyback_pkg::ST_REGULATE;
        end
        if (flt_new != '0) begin
          mode_d = flyback_pkg::ST_FAULT;
        end
      end
      flyback_pkg::ST_FAULT: begin
        // Stays biased, drains the supply until lockout
        mode_d = flyback_pkg::ST_FAULT;
      end
      default: begin
        mode_d = flyback_pkg::ST_LOCKOUT;
      end
    endcase

    if (!comp_s.lock_ok) begin
      mode_d = flyback_pkg::ST_LOCKOUT;
    end

    faults_d = faults_q | flt_new;

    if (mode_d == flyback_pkg::ST_FAULT) begin
      ph_d = flyback_pkg::PH_IDLE;
    end
    if (mode_d == flyback_pkg::ST_LOCKOUT) begin
      ph_d      = flyback_pkg::PH_IDLE;
      ss_d      = flyback_pkg::SS_START;
      ton_d     = flyback_pkg::TON_MAX_CYC;
      toff_d    = '0;
      ocp_cnt_d = 3'h0;
      seen_d    = 1'b0;
      fbl_d     = '0;
      faults_d  = '0;
    end

    drive_d.on         = (ph_d == flyback_pkg::PH_ON);
    drive_d.base_level = ton_lim[10:7];
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q    <= flyback_pkg::ST_LOCKOUT;
      ph_q      <= flyback_pkg::PH_IDLE;
      ss_q      <= flyback_pkg::SS_START;
      ton_q     <= flyback_pkg::TON_MAX_CYC;
      toff_q    <= '0;
      ocp_cnt_q <= 3'h0;
      seen_q    <= 1'b0;
      vs_prev_q <= 1'b0;
      fbl_q     <= '0;
      faults_q  <= '0;
      drive_q   <= '0;
      enable_q  <= 1'b0;
      startup_q <= 1'b1;
      heavy_q   <= 1'b0;
      varfreq_q <= 1'b0;
      for (int i = 0; i < flyback_pkg::SAMPLE_LAG; i++) begin
        fb_hist_q[i] <= '0;
      end
    end else begin
      mode_q    <= mode_d;
      ph_q      <= ph_d;
      ss_q      <= ss_d;
      ton_q     <= ton_d;
      toff_q    <= toff_d;
      ocp_cnt_q <= ocp_cnt_d;
      seen_q    <= seen_d;
      vs_prev_q <= comp_s.vsense;
      fbl_q     <= fbl_d;
      faults_q  <= faults_d;
      drive_q   <= drive_d;
      enable_q  <= (mode_d != flyback_pkg::ST_LOCKOUT);
      startup_q <= (mode_d == flyback_pkg::ST_LOCKOUT);
      heavy_q   <= (mode_d == flyback_pkg::ST_REGULATE) && (toff_d == '0) &&
                   (ton_d > flyback_pkg::TON_LIGHT);
      varfreq_q <= (toff_d != '0);
      fb_hist_q[0] <= fb_code;
      for (int i = 1; i < flyback_pkg::SAMPLE_LAG; i++) begin
        fb_hist_q[i] <= fb_hist_q[i-1];
      end
    end
  end

  assign drive               = drive_q;
  assign enable              = enable_q;
  assign startup_device_ctrl = startup_q;
  assign feedback_level      = fbl_q;
  assign load_heavy          = heavy_q;
  assign variable_freq       = varfreq_q;
  assign faults              = faults_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_cycle_end;
    (ph_q == flyback_pkg::PH_RESET) && vs_fall && comp_s.lock_ok;
  endsequence

  property p_start;
    (mode_q == flyback_pkg::ST_LOCKOUT) && comp_s.start_ok && comp_s.lock_ok
    |=> (mode_q == flyback_pkg::ST_SOFTSTART) && enable;
  endproperty
  a_start: assert property (p_start)
    else $error("soft-start not entered at start threshold");

  property p_lockout;
    !comp_s.lock_ok |=> (mode_q == flyback_pkg::ST_LOCKOUT) && !enable
                        && startup_device_ctrl;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("lockout did not drop enable");

  property p_startup_low;
    $rose(enable) |-> !startup_device_ctrl;
  endproperty
  a_startup_low: assert property (p_startup_low)
    else $error("startup control not pulled low with enable");

  property p_startup_rel;
    !enable |-> startup_device_ctrl;
  endproperty
  a_startup_rel: assert property (p_startup_rel)
    else $error("startup control not released before start-up");

  property p_peak_end;
    drive.on && (comp_s.ipeak || comp_s.overcurrent_protect) |=> !drive.on;
  endproperty
  a_peak_end: assert property (p_peak_end)
    else $error("on-pulse continued past current limit");

  property p_ocp_shut;
    drive.on && comp_s.overcurrent_protect && comp_s.lock_ok &&
    (ocp_cnt_q == (flyback_pkg::OCP_LIMIT - 3'h1))
    |=> (mode_q == flyback_pkg::ST_FAULT) ##1 !drive.on;
  endproperty
  a_ocp_shut: assert property (p_ocp_shut)
    else $error("repeated overcurrent did not shut down");

  property p_ton_cap;
    drive.on |-> (phase_cnt < flyback_pkg::TON_MAX_CYC);
  endproperty
  a_ton_cap: assert property (p_ton_cap)
    else $error("on-time exceeded cap");

  property p_reset_cap;
    (ph_q == flyback_pkg::PH_RESET) |-> (phase_cnt < RESET_LIM);
  endproperty
  a_reset_cap: assert property (p_reset_cap)
    else $error("reset wait exceeded limit");

  property p_no_sense;
    (ph_q == flyback_pkg::PH_RESET) && !seen_q && !vs_fall &&
    comp_s.lock_ok && (phase_cnt == flyback_pkg::VS_WAIT_CYC)
    |=> (mode_q == flyback_pkg::ST_FAULT) && faults.no_sense;
  endproperty
  a_no_sense: assert property (p_no_sense)
    else $error("missing aux sense did not shut down");

  property p_ss_widen;
    (mode_q == flyback_pkg::ST_SOFTSTART) ##0 s_cycle_end
    |=> (ss_q > $past(ss_q)) || (mode_q == flyback_pkg::ST_FAULT);
  endproperty
  a_ss_widen: assert property (p_ss_widen)
    else $error("soft-start pulse did not widen");

  property p_fault_hold;
    (mode_q == flyback_pkg::ST_FAULT) && comp_s.lock_ok
    |=> (mode_q == flyback_pkg::ST_FAULT) && !drive.on;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault left before lockout");

  property p_quiet;
    (mode_q == flyback_pkg::ST_LOCKOUT) |-> !drive.on && (toff_q == '0)
      && (faults == '0);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("state not cleared in lockout");

endmodule // flyback_ctrl

//--- rtl/flyback_pkg.sv
// Constants, types and timing counts of the flyback control core.
// Assumes a single 100 MHz clock; analog comparators sit outside.
package flyback_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned TON_MAX_NS   = 13800;
  localparam int unsigned RESET_MAX_NS = 110000;
  localparam int unsigned VS_WAIT_NS   = 2000;
  localparam int unsigned SW_FREQ_KHZ  = 72;

  localparam int unsigned CNT_W = 14;
  typedef logic [CNT_W-1:0] cnt_t;

  // Longest times round down
  localparam cnt_t TON_MAX_CYC = cnt_t'((TON_MAX_NS * CLK_MHZ) / 1000);
  localparam int unsigned RESET_MAX_CYC_DEF = (RESET_MAX_NS * CLK_MHZ) / 1000;
  localparam cnt_t VS_WAIT_CYC = cnt_t'((VS_WAIT_NS * CLK_MHZ) / 1000);
  localparam cnt_t PERIOD_CYC  = cnt_t'((CLK_MHZ * 1000) / SW_FREQ_KHZ);

  // Comparator trip points, in millivolts, set in the analog front end
  localparam int unsigned START_MV   = 11000;
  localparam int unsigned LOCKOUT_MV = 4000;
  localparam int unsigned OCP_MV     = 1150;

  ////////////////////////////////////////////////////////////////////////
  // Regulation settings
  localparam cnt_t TON_LIGHT  = 14'h0064;
  localparam cnt_t SS_START   = 14'h0014;
  localparam cnt_t SS_STEP    = 14'h0010;
  localparam cnt_t TOFF_MAX   = 14'h2000;
  localparam int unsigned SAMPLE_LAG = 4;

  localparam int unsigned FB_W = 8;
  typedef logic [FB_W-1:0] fb_t;
  localparam fb_t FB_REF = 8'hA0;
  localparam fb_t FB_SCP = 8'h30;

  localparam logic [2:0] OCP_LIMIT = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    ST_LOCKOUT   = 2'b00,
    ST_SOFTSTART = 2'b01,
    ST_REGULATE  = 2'b11,
    ST_FAULT     = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_ON    = 2'b01,
    PH_RESET = 2'b11,
    PH_WAIT  = 2'b10
  } phase_t;

  typedef struct packed {
    logic start_ok;
    logic lock_ok;
    logic ipeak;
    logic overcurrent_protect;
    logic vsense;
    logic overvoltage_protect;
  } comp_t;

  typedef struct packed {
    logic overvoltage_protect;
    logic short_circuit_protect;
    logic overcurrent_protect;
    logic isense;
    logic max_on;
    logic reset_to;
    logic no_sense;
  } fault_t;

  typedef struct packed {
    logic       on;
    logic [3:0] base_level;
  } drive_t;

endpackage

//--- rtl/flyback_pkg_dummy_guard.sv
// Spare design file: holds no logic.

//--- rtl/sync2.sv
// Two-flop synchroniser for a group of comparator levels.
// Assumes inputs are quasi-static compared with the clock.
`timescale 1ns/1ps
module sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule // sync2
